// file: pkg/acr_pkg.sv
// Constants, field layout and state codes of the aux converter readout block
package acr_pkg;

  // ---------------------------------------------------------------------------
  // Frame and result geometry
  // ---------------------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int RES_BITS = 10;
  localparam int HOLD_BITS = 6;
  localparam int SUM_BITS = 15;
  localparam int CONV_EDGES = 12;
  localparam logic [4:0] FRAME_CNT = 5'h10;
  localparam logic [4:0] SHIFT_DONE_CNT = 5'h0f;
  localparam logic [3:0] EDGE_LAST = 4'hb;

  // ---------------------------------------------------------------------------
  // Instruction layout
  // ---------------------------------------------------------------------------
  localparam int ADDR_LSB = 12;
  localparam int START_POS = 0;
  localparam int INSEL_LSB = 2;
  localparam int AVG_LSB = 4;
  localparam int DIV_LSB = 7;
  localparam int MODE_POS = 10;
  localparam logic [3:0] AUX_ADDR = 4'h5;
  localparam logic [3:0] NULL_ADDR = 4'hf;

  // ---------------------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------------------
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [2:0] AVG_RST = 3'h0;
  localparam logic [1:0] INSEL_RST = 2'h0;
  localparam logic MODE_RST = 1'b0;
  localparam logic [2:0] AVG_CAP = 3'h5;
  localparam logic [1:0] AVG_CAP_CODE = 2'h3;

  // ---------------------------------------------------------------------------
  // Readout state codes
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_BUSY = 5'h02,
    ST_READY = 5'h04,
    ST_SHIFT = 5'h08,
    ST_LOCK = 5'h10
  } acr_state_t;

endpackage

// file: pkg/acr_seq_if.sv
// Link between the readout control and the conversion sequencer
`timescale 1ns/1ps
interface acr_seq_if;
  logic [2:0] div_sel;
  logic run;
  logic sample;
  logic pass_done;
  modport ctrl (output div_sel, output run, input sample, input pass_done);
  modport seq (input div_sel, input run, output sample, output pass_done);
endinterface

// file: src/acr_conv_seq.sv
// Conversion clock divider and per-pass edge sequencer
`timescale 1ns/1ps
module acr_conv_seq (
  input wire logic clk,
  input wire logic rstn,
  acr_seq_if.seq sif
);

  // ---------------------------------------------------------------------------
  // Divider and edge counter
  // ---------------------------------------------------------------------------
  logic [6:0] pre;
  logic [6:0] next_pre;
  logic [3:0] edge_cnt;
  logic [3:0] next_edge_cnt;
  logic [6:0] lim;
  logic tick;

  // Power-of-two divisor from the select code
  assign lim = 7'((8'h01 << sif.div_sel) - 8'h01);
  assign tick = sif.run && (pre == lim);
  assign sif.sample = tick && (edge_cnt == 4'h0);
  assign sif.pass_done = tick && (edge_cnt == acr_pkg::EDGE_LAST);

  // Next counts; both rest at zero while idle
  always_comb begin
    next_pre = pre;
    next_edge_cnt = edge_cnt;
    if (!sif.run) begin
      next_pre = 7'h00;
      next_edge_cnt = 4'h0;
    end else if (tick) begin
      next_pre = 7'h00;
      next_edge_cnt = sif.pass_done ? 4'h0 : 4'(edge_cnt + 4'h1);
    end else begin
      next_pre = 7'(pre + 7'h01);
    end
  end

  // Register the counts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre <= 7'h00;
      edge_cnt <= 4'h0;
    end else begin
      pre <= next_pre;
      edge_cnt <= next_edge_cnt;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_pass_twelve_edges: assert property (
    (sif.sample && sif.div_sel == 3'h0) |-> ##11 (sif.pass_done || !sif.run))
    else $error("pass did not end on twelfth edge");
  a_div_two_period: assert property (
    (tick && sif.div_sel == 3'h1 && $stable(sif.div_sel)) |=> (!tick ##1 (tick || !sif.run)))
    else $error("divide by two tick period wrong");

endmodule

// file: src/acr_readout.sv
// Aux converter control, conversion sequencing and serial result readout
`timescale 1ns/1ps
module acr_readout (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_wake_n,
  input wire logic din,
  input wire logic [9:0] adc_code,
  output logic dout,
  output logic dout_oe,
  output logic [1:0] input_sel,
  output logic [2:0] avg_sel,
  output logic [2:0] clk_div_sel,
  output logic result_output_mode_bit,
  output logic conv_start_bit,
  output logic adc_sample,
  output logic [9:0] adc_result,
  output logic lockout
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  acr_pkg::acr_state_t state;
  acr_pkg::acr_state_t next_state;
  acr_pkg::acr_state_t st_a;
  logic sclk_q;
  logic cs_q;
  logic [15:0] rx_shift;
  logic [15:0] next_rx_shift;
  logic [4:0] rx_cnt;
  logic [4:0] next_rx_cnt;
  logic [15:0] tx_shift;
  logic [15:0] next_tx_shift;
  logic [4:0] tx_cnt;
  logic [4:0] next_tx_cnt;
  logic [1:0] next_input_sel;
  logic [2:0] next_avg_sel;
  logic [2:0] next_clk_div_sel;
  logic next_mode;
  logic start_mode;
  logic next_start_mode;
  logic [2:0] run_avg;
  logic [2:0] next_run_avg;
  logic [5:0] pass_cnt;
  logic [5:0] next_pass_cnt;
  logic [14:0] acc;
  logic [14:0] next_acc;
  logic [14:0] sum;
  logic [9:0] next_result;
  logic next_dout;
  logic next_dout_oe;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_ok;
  logic cmd_hit;
  logic cmd_start;
  logic [2:0] avg_eff;
  logic [5:0] pass_last;

  acr_seq_if sif ();

  // ---------------------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------------------
  acr_conv_seq u_seq (
    .clk(clk),
    .rstn(rstn),
    .sif(sif)
  );

  assign sif.div_sel = clk_div_sel;
  assign sif.run = (state == acr_pkg::ST_BUSY);
  assign adc_sample = sif.sample;

  // ---------------------------------------------------------------------------
  // Serial edge detection and instruction decode
  // ---------------------------------------------------------------------------
  assign cs_fall = cs_q && !cs_wake_n;
  assign cs_rise = !cs_q && cs_wake_n;
  assign sclk_rise = !sclk_q && sclk && !cs_wake_n;
  assign sclk_fall = sclk_q && !sclk && !cs_wake_n;
  assign frame_ok = cs_rise && (rx_cnt == acr_pkg::FRAME_CNT);
  // Address 1111 never decodes to a register
  assign cmd_hit = frame_ok && (rx_shift[15:acr_pkg::ADDR_LSB] != acr_pkg::NULL_ADDR)
                   && (rx_shift[15:acr_pkg::ADDR_LSB] == acr_pkg::AUX_ADDR);
  assign cmd_start = rx_shift[acr_pkg::START_POS];

  // Effective averaging code; 11x saturates to 32 passes
  assign avg_eff = (rx_shift[acr_pkg::AVG_LSB + 1 +: 2] == acr_pkg::AVG_CAP_CODE)
                   ? acr_pkg::AVG_CAP : rx_shift[acr_pkg::AVG_LSB +: 3];
  assign pass_last = 6'((7'h01 << run_avg) - 7'h01);
  assign sum = 15'(acc + {5'h00, adc_code});

  // Shift in the instruction on rising serial clock
  always_comb begin
    next_rx_shift = rx_shift;
    next_rx_cnt = rx_cnt;
    if (cs_fall) begin
      next_rx_cnt = 5'h00;
    end else if (sclk_rise) begin
      next_rx_shift = {rx_shift[14:0], din};
      if (rx_cnt != acr_pkg::FRAME_CNT) begin
        next_rx_cnt = 5'(rx_cnt + 5'h01);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration, conversion and readout state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_tx_shift = tx_shift;
    next_tx_cnt = tx_cnt;
    next_input_sel = input_sel;
    next_avg_sel = avg_sel;
    next_clk_div_sel = clk_div_sel;
    next_mode = result_output_mode_bit;
    next_start_mode = start_mode;
    next_run_avg = run_avg;
    next_pass_cnt = pass_cnt;
    next_acc = acc;
    next_result = adc_result;
    st_a = state;
    // Readout frame: load on chip-select fall, advance on falling clock
    unique case (state)
      acr_pkg::ST_READY: begin
        if (cs_fall && result_output_mode_bit) begin
          st_a = acr_pkg::ST_SHIFT;
          next_tx_shift = {adc_result, {acr_pkg::HOLD_BITS{adc_result[0]}}};
          next_tx_cnt = 5'h00;
        end
      end
      acr_pkg::ST_SHIFT: begin
        if (cs_rise) begin
          // Result counts as read only after at least 15 falling serial clocks in the frame
          st_a = (tx_cnt >= acr_pkg::SHIFT_DONE_CNT) ? acr_pkg::ST_IDLE
                 : acr_pkg::ST_READY;
        end else if (sclk_fall) begin
          next_tx_shift = {tx_shift[14:0], tx_shift[0]};
          if (tx_cnt != acr_pkg::FRAME_CNT) begin
            next_tx_cnt = 5'(tx_cnt + 5'h01);
          end
        end
      end
      acr_pkg::ST_BUSY: begin
        // One pass ends; accumulate and finish after the last
        if (sif.pass_done) begin
          next_acc = sum;
          next_pass_cnt = 6'(pass_cnt + 6'h01);
          if (pass_cnt == pass_last) begin
            next_result = 10'(sum >> run_avg);
            st_a = acr_pkg::ST_READY;
          end
        end
      end
      acr_pkg::ST_IDLE, acr_pkg::ST_LOCK: begin
      end
    endcase
    next_state = st_a;
    // Instruction taken at chip-select rise
    if (cmd_hit) begin
      next_input_sel = rx_shift[acr_pkg::INSEL_LSB +: 2];
      next_avg_sel = rx_shift[acr_pkg::AVG_LSB +: 3];
      next_clk_div_sel = rx_shift[acr_pkg::DIV_LSB +: 3];
      next_mode = rx_shift[acr_pkg::MODE_POS];
      unique case (st_a)
        acr_pkg::ST_IDLE: begin
          if (cmd_start) begin
            next_state = acr_pkg::ST_BUSY;
            next_start_mode = rx_shift[acr_pkg::MODE_POS];
            next_run_avg = avg_eff;
            next_pass_cnt = 6'h00;
            next_acc = 15'h0000;
          end
        end
        acr_pkg::ST_READY, acr_pkg::ST_SHIFT: begin
          // Unread result blocks a start; after a mode-0 start it locks
          if (cmd_start && !start_mode) begin
            next_state = acr_pkg::ST_LOCK;
          end
        end
        acr_pkg::ST_LOCK: begin
          if (!cmd_start) begin
            next_state = acr_pkg::ST_IDLE;
          end
        end
        acr_pkg::ST_BUSY: begin
        end
      endcase
    end
  end

  // Data-out level and enable follow the next state
  always_comb begin
    next_dout = 1'b0;
    next_dout_oe = 1'b0;
    unique case (next_state)
      acr_pkg::ST_BUSY: begin
        next_dout = 1'b1;
        next_dout_oe = 1'b1;
      end
      acr_pkg::ST_READY: begin
        next_dout_oe = 1'b1;
      end
      acr_pkg::ST_SHIFT: begin
        next_dout = next_tx_shift[15];
        next_dout_oe = 1'b1;
      end
      acr_pkg::ST_IDLE, acr_pkg::ST_LOCK: begin
        next_dout_oe = 1'b0;
      end
    endcase
  end

  // Register all state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= acr_pkg::ST_IDLE;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      rx_shift <= 16'h0000;
      rx_cnt <= 5'h00;
      tx_shift <= 16'h0000;
      tx_cnt <= 5'h00;
      input_sel <= acr_pkg::INSEL_RST;
      avg_sel <= acr_pkg::AVG_RST;
      clk_div_sel <= acr_pkg::DIV_RST;
      result_output_mode_bit <= acr_pkg::MODE_RST;
      start_mode <= 1'b0;
      run_avg <= 3'h0;
      pass_cnt <= 6'h00;
      acc <= 15'h0000;
      adc_result <= 10'h000;
      dout <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      state <= next_state;
      sclk_q <= sclk;
      cs_q <= cs_wake_n;
      rx_shift <= next_rx_shift;
      rx_cnt <= next_rx_cnt;
      tx_shift <= next_tx_shift;
      tx_cnt <= next_tx_cnt;
      input_sel <= next_input_sel;
      avg_sel <= next_avg_sel;
      clk_div_sel <= next_clk_div_sel;
      result_output_mode_bit <= next_mode;
      start_mode <= next_start_mode;
      run_avg <= next_run_avg;
      pass_cnt <= next_pass_cnt;
      acc <= next_acc;
      adc_result <= next_result;
      dout <= next_dout;
      dout_oe <= next_dout_oe;
    end
  end

  // Start bit reads back as running; lockout shows disabled data-out
  assign conv_start_bit = (state == acr_pkg::ST_BUSY);
  assign lockout = (state == acr_pkg::ST_LOCK);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_busy_drives_high: assert property (conv_start_bit |-> (dout_oe && dout))
    else $error("data-out not high while converting");
  a_ready_drives_low: assert property ((state == acr_pkg::ST_READY) |-> (dout_oe && !dout))
    else $error("data-out not low with result ready");
  a_float_when_idle: assert property ((state == acr_pkg::ST_IDLE) |-> !dout_oe)
    else $error("data-out driven in idle");
  a_shift_msb_first: assert property (
    (state == acr_pkg::ST_READY && cs_fall && result_output_mode_bit)
      |=> (state == acr_pkg::ST_SHIFT && dout == $past(adc_result[9])))
    else $error("first bit is not the result msb");
  a_shift_hold_tail: assert property (
    (state == acr_pkg::ST_SHIFT && sclk_fall && !cs_rise)
      |=> (tx_shift == {$past(tx_shift[14:0]), $past(tx_shift[0])}))
    else $error("shift or tail hold wrong");
  a_mode_zero_hides: assert property ((cs_fall && !result_output_mode_bit)
    |=> (state != acr_pkg::ST_SHIFT))
    else $error("result shifted with output mode off");
  a_pending_blocks: assert property ((state == acr_pkg::ST_READY)
    |=> (state != acr_pkg::ST_BUSY))
    else $error("conversion started over unread result");
  a_restart_locks: assert property (
    (state == acr_pkg::ST_READY && cmd_hit && cmd_start && !start_mode)
      |=> (lockout && !dout_oe))
    else $error("restart after mode-0 did not lock");
  a_null_addr_keeps: assert property (
    (frame_ok && rx_shift[15:acr_pkg::ADDR_LSB] == acr_pkg::NULL_ADDR)
      |=> ($stable(clk_div_sel) && $stable(avg_sel) && $stable(input_sel)
           && $stable(result_output_mode_bit)))
    else $error("write to address 1111 changed a field");
  a_auto_clear: assert property ($fell(conv_start_bit) |-> (state == acr_pkg::ST_READY))
    else $error("start bit cleared without a result");

  c_frame_read: cover property ((state == acr_pkg::ST_SHIFT) ##1 (state == acr_pkg::ST_IDLE));
  c_lock_entered: cover property ($rose(lockout));
  c_chained: cover property ((state == acr_pkg::ST_SHIFT) ##1 (state == acr_pkg::ST_BUSY));
  c_averaged: cover property ($fell(conv_start_bit) && run_avg != 3'h0);

endmodule

// file: tb/acr_host_model.sv
// Host controller model driving the 4-wire serial port
`timescale 1ns/1ps
module acr_host_model (
  input wire logic clk,
  input wire logic dout_line,
  output logic sclk,
  output logic cs_wake_n,
  output logic din
);
  // ---------------------------------------------------------------------------
  // Idle levels and frame task
  // ---------------------------------------------------------------------------
  // Serial clock stands low and select high between frames
  initial begin
    sclk = 1'b0;
    cs_wake_n = 1'b1;
    din = 1'b1;
  end

  // Wait whole system clocks
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Sixteen bits out on din, sixteen captured before each falling edge
  task automatic frame(input logic [15:0] word, output logic [15:0] rd);
    @(posedge clk);
    cs_wake_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din <= word[i];
      pause(4);
      sclk <= 1'b1;
      pause(4);
      rd[i] = dout_line;
      sclk <= 1'b0;
    end
    pause(4);
    cs_wake_n <= 1'b1;
    din <= 1'b1;
  endtask
endmodule

// file: tb/aux_adc_control_readout_tb_top.sv
// Self-checking testbench of the aux converter readout block
`timescale 1ns/1ps
module aux_adc_control_readout_tb_top;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] adc_code = 10'h000;
  logic [9:0] code_a = 10'h2a5;
  logic [9:0] code_b = 10'h2a7;
  logic flip = 1'b0;
  logic sclk, cs_wake_n, din, dout, dout_oe, result_output_mode_bit;
  logic conv_start_bit, adc_sample, lockout;
  logic [1:0] input_sel;
  logic [2:0] avg_sel, clk_div_sel;
  logic [9:0] adc_result;
  logic [15:0] rd;
  wire dout_line = dout_oe ? dout : 1'bz;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_samp = 0;
  int gap = 0;
  int last_at = 0;
  int busy_cyc = 0;

  acr_readout dut (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_wake_n(cs_wake_n), .din(din),
    .adc_code(adc_code), .dout(dout), .dout_oe(dout_oe), .input_sel(input_sel),
    .avg_sel(avg_sel), .clk_div_sel(clk_div_sel),
    .result_output_mode_bit(result_output_mode_bit), .conv_start_bit(conv_start_bit),
    .adc_sample(adc_sample), .adc_result(adc_result), .lockout(lockout));
  acr_host_model host (.clk(clk), .dout_line(dout_line), .sclk(sclk),
    .cs_wake_n(cs_wake_n), .din(din));

  // Clock
  always #4 clk = ~clk;

  // Pass counter, converter stimulus and timeout
  always @(posedge clk) begin
    cyc++;
    if (conv_start_bit === 1'b1) begin
      busy_cyc++;
    end
    if (adc_sample === 1'b1) begin
      n_samp++;
      gap = cyc - last_at;
      last_at = cyc;
      adc_code <= flip ? code_b : code_a;
      flip = ~flip;
    end
    if (cyc == 100000) begin
      mismatches++;
      conclude();
    end
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] mk(logic m, logic [2:0] d, logic [2:0] a, logic [1:0] s,
                                     logic st);
    return {acr_pkg::AUX_ADDR, 1'b0, m, d, a, s, 1'b0, st};
  endfunction

  function automatic int n_of(logic [2:0] a);
    return (a[2] & a[1]) ? 32 : (1 << a);
  endfunction

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic send(input logic [15:0] w);
    host.frame(w, rd);
    settle();
  endtask

  task automatic start_conv(input logic m, input logic [2:0] d, input logic [2:0] a);
    flip = 1'b0;
    n_samp = 0;
    busy_cyc = 0;
    send(mk(m, d, a, 2'h0, 1'b1));
    chk("busy", 16'h0001, conv_start_bit);
    chk("busy_oe", 16'h0001, dout_oe);
    chk("busy_dout", 16'h0001, dout);
  endtask

  task automatic wait_done();
    for (int i = 0; i < 20000 && conv_start_bit !== 1'b0; i++) @(posedge clk);
    settle();
    chk("conv_end", 16'h0000, conv_start_bit);
    chk("ready_oe", 16'h0001, dout_oe);
    chk("ready_dout", 16'h0000, dout);
  endtask

  task automatic read_check(input logic [9:0] res);
    host.frame(16'hffff, rd);
    chk("read_bits", {res, {6{res[0]}}}, rd);
    settle();
    chk("float_oe", 16'h0000, dout_oe);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk("oe", 16'h0000, dout_oe);
    chk("div", 16'h0000, clk_div_sel);
    chk("mode", 16'h0000, result_output_mode_bit);
    chk("avg", 16'h0000, avg_sel);
    chk("insel", 16'h0000, input_sel);
    chk("start", 16'h0000, conv_start_bit);
  endtask

  task automatic t_config();
    for (int i = 0; i < 4; i++) begin
      send(mk(1'b1, 3'h3, 3'h2, i[1:0], 1'b0));
      chk("insel", i[15:0], input_sel);
    end
    send(16'hffff);
    chk("cfg", 16'h016b, {result_output_mode_bit, clk_div_sel, avg_sel, input_sel});
    send(mk(1'b0, 3'h0, 3'h0, 2'h0, 1'b0));
    chk("cfg0", 16'h0000, {result_output_mode_bit, clk_div_sel, avg_sel});
  endtask

  task automatic t_one(input logic [2:0] d, input logic [2:0] a);
    int n;
    int t;
    n = n_of(a);
    t = (12 * n) << d;
    start_conv(1'b1, d, a);
    wait_done();
    chk("result", (n == 1) ? code_a : 10'h2a6, adc_result);
    chk("passes", n[15:0], n_samp[15:0]);
    chk("conv_time", t[15:0], busy_cyc[15:0]);
    // Gap between passes only exists with averaging
    if (n > 1) begin
      chk("pass_gap", 16'd12 << d, gap[15:0]);
    end
    read_check((n == 1) ? code_a : 10'h2a6);
  endtask

  task automatic t_busy_write();
    start_conv(1'b1, 3'h4, 3'h1);
    send(mk(1'b1, 3'h4, 3'h1, 2'h0, 1'b0));
    chk("still_busy", 16'h0001, conv_start_bit);
    wait_done();
    chk("passes", 16'h0002, n_samp[15:0]);
    read_check(10'h2a6);
  endtask

  task automatic t_lock();
    start_conv(1'b0, 3'h0, 3'h0);
    wait_done();
    host.frame(16'hffff, rd);
    chk("hidden_bits", 16'h0000, rd);
    settle();
    send(mk(1'b1, 3'h0, 3'h0, 2'h0, 1'b1));
    chk("lock", 16'h0001, lockout);
    chk("lock_oe", 16'h0000, dout_oe);
    chk("no_conv", 16'h0000, conv_start_bit);
    send(mk(1'b0, 3'h0, 3'h0, 2'h0, 1'b0));
    chk("unlock", 16'h0000, lockout);
  endtask

  task automatic t_chain();
    start_conv(1'b1, 3'h0, 3'h0);
    wait_done();
    code_a = 10'h133;
    flip = 1'b0;
    host.frame(mk(1'b1, 3'h0, 3'h0, 2'h0, 1'b1), rd);
    chk("chain_bits", {10'h2a5, {6{1'b1}}}, rd);
    settle();
    chk("chain_busy", 16'h0001, conv_start_bit);
    wait_done();
    read_check(10'h133);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    settle();
    t_reset();
    t_config();
    for (int d = 0; d < 8; d++) t_one(d[2:0], 3'h1);
    for (int a = 0; a < 8; a++) t_one(3'h0, a[2:0]);
    t_busy_write();
    t_lock();
    t_chain();
    conclude();
  end
endmodule
